// ==== tfs_consts.svh ====
// Constants for the tape format selector: density codes, format codes, offsets, timing.
`ifndef TFS_CONSTS_SVH
`define TFS_CONSTS_SVH

// Density codes
`define TFS_DEN_HDC 8'h8c
`define TFS_DEN_HD 8'h15
`define TFS_DEN_LDC 8'h90
`define TFS_DEN_LD 8'h14
`define TFS_DEN_DEFAULT 8'h8c
// Write format codes
`define TFS_WTF_HD 3'h0
`define TFS_WTF_LDC 3'h3
`define TFS_WTF_LD 3'h1
`define TFS_WTF_HDC 3'h2
// Command opcodes
`define TFS_OP_READ 8'h08
`define TFS_OP_SPACE 8'h11
`define TFS_OP_WRITE 8'h0a
`define TFS_OP_WFM 8'h10
`define TFS_OP_MSEL 8'h15
// Register byte offsets
`define TFS_REG_CTRL 12'h000
`define TFS_REG_STAT 12'h004
`define TFS_REG_CMD 12'h008
`define TFS_REG_DEN 12'h00c
// Control field positions
`define TFS_CTRL_DCE_BIT 0
`define TFS_CTRL_DDE_BIT 1
// Reset values
`define TFS_CTRL_RST 2'h3
// Handshake timing: one wait state
`define TFS_APB_WAIT 1

`endif

// ==== tfs_pkg.sv ====
// Types shared by the tape format selector.
`default_nettype none
package tfs_pkg;
    typedef enum logic [1:0] {
        TFS_FMT_HDC = 2'h0,
        TFS_FMT_HD = 2'h1,
        TFS_FMT_LDC = 2'h2,
        TFS_FMT_LD = 2'h3
    } tfs_fmt_e;
    typedef enum logic [2:0] {
        TFS_MARK_NONE = 3'h0,
        TFS_MARK_LFM_BOT = 3'h1,
        TFS_MARK_LFM_EOT = 3'h2,
        TFS_MARK_SM = 3'h3,
        TFS_MARK_EOD = 3'h4
    } tfs_mark_e;
endpackage : tfs_pkg
`default_nettype wire

// ==== tfs_fmt_table.sv ====
// Small registered lookup from format to density and write-format code.
`default_nettype none
`include "tfs_consts.svh"
module tfs_fmt_table (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Lookup
    input wire tfs_pkg::tfs_fmt_e fmt_i,
    output logic [7:0] density_o,
    output logic [2:0] wtf_o
);
    import tfs_pkg::*;

    logic [7:0] den_d;
    logic [2:0] wtf_d;

    // Table of density codes and format codes
    always_comb begin
        unique case (fmt_i)
            TFS_FMT_HDC: begin den_d = `TFS_DEN_HDC; wtf_d = `TFS_WTF_HDC; end
            TFS_FMT_HD: begin den_d = `TFS_DEN_HD; wtf_d = `TFS_WTF_HD; end
            TFS_FMT_LDC: begin den_d = `TFS_DEN_LDC; wtf_d = `TFS_WTF_LDC; end
            TFS_FMT_LD: begin den_d = `TFS_DEN_LD; wtf_d = `TFS_WTF_LD; end
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            density_o <= `TFS_DEN_DEFAULT;
            wtf_o <= `TFS_WTF_HDC;
        end else begin
            density_o <= den_d;
            wtf_o <= wtf_d;
        end
    end
endmodule : tfs_fmt_table
`default_nettype wire

// ==== tfs_top.sv ====
// Tape format selector: density tracking, append legality and write format report.
//
// Functional notes
// - HDC appends: filemark sides, setmark sides, end
// - HD appends: filemark sides and end only
// - LDC appends: end or filemark tape-start side
// - LD appends: blank end or filemark start side
// - HDC append forces density and both compress bits
// - Report write format as 3-bit code
// - Reads of compressed data are decompressed
// - Recorded format detected without host density
// - Leaving start adopts recorded tape's density
// - Adopted density held until unload after write
// - Write at start overwrites in retained format
// - Blank tape unselected uses power-on default
// - Only one recording format per tape
// - Append elsewhere uses recorded format
`default_nettype none
`include "tfs_consts.svh"
module tfs_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Tape status pins from the transport
    input wire logic tape_loaded_i,
    input wire logic logical_tape_start_i,
    input wire logic tape_blank_i,
    input wire logic [1:0] recorded_fmt_i,
    input wire logic [2:0] position_mark_i,
    // Drive controls
    output logic [7:0] density_o,
    output logic [2:0] active_write_format_code_o,
    output logic compress_on_write_enable_o,
    output logic decompress_on_read_enable_o,
    output logic write_go_o,
    output logic write_reject_o
);
    import tfs_pkg::*;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    wire logic [7:0] pin_raw = {tape_loaded_i, logical_tape_start_i, tape_blank_i, recorded_fmt_i, position_mark_i};

    // Two stages for every transport pin; only stage two is read
    // Reset to all zero: unloaded, no mark, so nothing is adopted early
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Stage-two view of the transport; the recorded format field
    // is only meaningful on a written tape, so users below qualify it
    // Limitation: a pin change is seen two edges late by all logic
    wire logic loaded = pin_s2_q[7];
    wire logic at_start = pin_s2_q[6];
    wire logic blank = pin_s2_q[5];
    wire tfs_fmt_e rec_fmt = tfs_fmt_e'(pin_s2_q[4:3]);
    wire tfs_mark_e mark = tfs_mark_e'(pin_s2_q[2:0]);

    // ************************************************
    // Helper functions
    // ************************************************
    // Density code to format; unknown codes give an invalid flag
    // Bit two set means no known format, so a stray code can never
    // be mistaken for the default format
    function automatic logic [2:0] den_to_fmt(input logic [7:0] den);
        logic [2:0] r;
        r = 3'h4;
        if (den == `TFS_DEN_HDC) r = {1'b0, TFS_FMT_HDC};
        if (den == `TFS_DEN_HD) r = {1'b0, TFS_FMT_HD};
        if (den == `TFS_DEN_LDC) r = {1'b0, TFS_FMT_LDC};
        if (den == `TFS_DEN_LD) r = {1'b0, TFS_FMT_LD};
        return r;
    endfunction : den_to_fmt

    // Append legality for each format at a given mark
    // The tape-start side of a long filemark and the end of data are shared by all four;
    // the low-density formats refuse setmarks and the far filemark side
    function automatic logic append_ok(input tfs_fmt_e f, input tfs_mark_e m);
        logic ok;
        ok = 1'b0;
        unique case (f)
            TFS_FMT_HDC: ok = (m != TFS_MARK_NONE);
            TFS_FMT_HD: ok = (m == TFS_MARK_LFM_BOT) || (m == TFS_MARK_LFM_EOT) || (m == TFS_MARK_EOD);
            TFS_FMT_LDC: ok = (m == TFS_MARK_LFM_BOT) || (m == TFS_MARK_EOD);
            TFS_FMT_LD: ok = (m == TFS_MARK_LFM_BOT) || (m == TFS_MARK_EOD);
        endcase
        return ok;
    endfunction : append_ok

    // ************************************************
    // APB slave
    // ************************************************
    // Bus, control and command state
    logic acc_q;
    logic [1:0] ctrl_q;
    logic [7:0] sel_den_q;
    logic sel_valid_q;
    tfs_fmt_e fmt_q;
    logic adopted_q;
    logic locked_q;
    logic reject_q;
    logic go_q;
    logic [7:0] cmd_q;
    logic cmd_pend_q;

    // First access cycle; answering one cycle later keeps the
    // read mux and decode off the ready path
    wire logic acc_start = psel_i && penable_i && !acc_q && !pready_o;
    // Completion edge: second access cycle, ready already shown
    wire logic done = psel_i && penable_i && acc_q;
    wire logic wr = done && pwrite_i;
    // Full address compare; byte lanes are not decoded
    wire logic sel_ctrl = paddr_i == `TFS_REG_CTRL;
    wire logic sel_stat = paddr_i == `TFS_REG_STAT;
    wire logic sel_cmd = paddr_i == `TFS_REG_CMD;
    wire logic sel_den = paddr_i == `TFS_REG_DEN;
    wire logic mapped = sel_ctrl || sel_stat || sel_cmd || sel_den;
    // Density write decoded once here, used by the selection path
    wire logic [2:0] wr_den_fmt = den_to_fmt(pwdata_i[7:0]);

    // Read mux, zero above the used bits
    // Unmapped offsets read as zero as well as raising the error
    wire logic [31:0] rd_mux =
        sel_ctrl ? {30'h0, ctrl_q} :
        sel_stat ? {20'h0, reject_q, locked_q, adopted_q, sel_valid_q, loaded, at_start, blank, fmt_q,
                    active_write_format_code_o} :
        sel_cmd ? {23'h0, cmd_pend_q, cmd_q} :
        sel_den ? {24'h0, density_o} : 32'h0;

    // One wait state: access phase answers on its second cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_q <= 1'b0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end else begin
            acc_q <= acc_start;
            pready_o <= acc_start;
            pslverr_o <= acc_start && !mapped;
            prdata_o <= (psel_i && !pwrite_i) ? rd_mux : 32'h0;
        end
    end

    // ************************************************
    // Command decode
    // ************************************************
    wire logic cmd_wr = wr && sel_cmd;
    // Opcode sits in the low byte; upper bits are ignored
    wire logic [7:0] op = pwdata_i[7:0];
    wire logic op_move = cmd_wr && (op == `TFS_OP_READ || op == `TFS_OP_SPACE);
    wire logic op_write = cmd_wr && (op == `TFS_OP_WRITE || op == `TFS_OP_WFM);
    // Density selection only counts at the tape start and before lock
    wire logic op_msel = wr && sel_den && at_start && !wr_den_fmt[2] && !locked_q;
    // Recorded format is only trusted on a written tape
    wire logic written = loaded && !blank;
    // Leaving the start of a written tape adopts its format
    wire logic adopt = op_move && at_start && written && !locked_q;
    // Writes off the start must land on a legal point of the recorded format
    wire logic legal = at_start || blank || append_ok(written ? rec_fmt : fmt_q, mark);
    wire logic write_ok = op_write && legal;

    // Format source priority
    // Unload first, so a stale format cannot outlive the cartridge;
    // then host selection, adoption and append in that order
    wire logic [2:0] sel_fmt = den_to_fmt(sel_den_q);
    tfs_fmt_e fmt_d;
    always_comb begin
        fmt_d = fmt_q;
        if (!loaded) begin
            fmt_d = sel_valid_q ? tfs_fmt_e'(sel_fmt[1:0]) : TFS_FMT_HDC;
        end else if (op_msel) begin
            fmt_d = tfs_fmt_e'(wr_den_fmt[1:0]);
        end else if (adopt) begin
            fmt_d = rec_fmt;
        end else if (write_ok && !at_start && written) begin
            // A refused write leaves the format alone
            fmt_d = rec_fmt;
        end
    end

    // ************************************************
    // Format state
    // ************************************************
    // Format, selection and lock; unload clears the adopted lock
    // The selection itself survives unload, like any other mode setting;
    // the lock does not, so the next cartridge can be reformatted
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fmt_q <= TFS_FMT_HDC;
            sel_den_q <= `TFS_DEN_DEFAULT;
            sel_valid_q <= 1'b0;
            adopted_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            fmt_q <= fmt_d;
            if (op_msel) begin
                sel_den_q <= pwdata_i[7:0];
                sel_valid_q <= 1'b1;
            end
            // Adoption is only remembered while the cartridge stays in
            adopted_q <= loaded && (adopted_q || adopt);
            locked_q <= loaded && (locked_q || (adopted_q && write_ok));
        end
    end

    // Control bits; HDC append overrides both enables
    // Both sources come from the bus at different offsets,
    // so they never meet in one cycle
    logic [1:0] ctrl_d;
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr && sel_ctrl) begin
            ctrl_d = pwdata_i[1:0];
        end
        if (write_ok && !at_start && written && rec_fmt == TFS_FMT_HDC) begin
            ctrl_d = 2'h3;
        end
    end

    // Enables come up set so a fresh drive compresses by default
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= `TFS_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Command log and write outcome; reject is sticky, a new legal write clears it
    // Only writes touch the reject flag, so a READ or SPACE in between
    // leaves the last verdict visible to software
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_q <= 8'h00;
            cmd_pend_q <= 1'b0;
            go_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            if (cmd_wr) begin
                cmd_q <= op;
            end
            cmd_pend_q <= cmd_wr;
            go_q <= write_ok;
            if (op_write) begin
                reject_q <= !legal;
            end
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    // Density and format code come from one registered table, so both
    // outputs always change on the same edge
    tfs_fmt_table u_table (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .fmt_i(fmt_q),
        .density_o(density_o),
        .wtf_o(active_write_format_code_o)
    );

    // Decompression follows the recorded data on read or the host bit
    // Compression only applies to the compressed formats, whatever the
    // host bit says; outputs stay one edge behind the state they report
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compress_on_write_enable_o <= 1'b1;
            decompress_on_read_enable_o <= 1'b1;
            write_go_o <= 1'b0;
            write_reject_o <= 1'b0;
        end else begin
            compress_on_write_enable_o <= ctrl_q[`TFS_CTRL_DCE_BIT] &&
                (fmt_q == TFS_FMT_HDC || fmt_q == TFS_FMT_LDC);
            decompress_on_read_enable_o <= ctrl_q[`TFS_CTRL_DDE_BIT] ||
                (written && (rec_fmt == TFS_FMT_HDC || rec_fmt == TFS_FMT_LDC));
            write_go_o <= go_q;
            write_reject_o <= reject_q;
        end
    end
endmodule : tfs_top
`default_nettype wire

// ==== tfs_chk.sv ====
// Port checker for the tape format selector.
`default_nettype none
`include "tfs_consts.svh"
module tfs_chk (
    // Clock, reset and bus
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Tape pins and drive controls
    input wire logic logical_tape_start_i,
    input wire logic tape_blank_i,
    input wire logic [7:0] density_o,
    input wire logic [2:0] active_write_format_code_o,
    input wire logic compress_on_write_enable_o,
    input wire logic decompress_on_read_enable_o,
    input wire logic write_go_o,
    input wire logic write_reject_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // One wait state, then a single-cycle answer
    a_bus_wait: assert property ($rose(psel_i && penable_i) |=> pready_o) else $error("late answer");
    a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
    a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    // Format code follows the density in force
    a_code_hdc: assert property (density_o == `TFS_DEN_HDC |-> active_write_format_code_o == `TFS_WTF_HDC)
        else $error("bad code");
    a_code_hd: assert property (density_o == `TFS_DEN_HD |-> active_write_format_code_o == `TFS_WTF_HD)
        else $error("bad code");
    a_code_ldc: assert property (density_o == `TFS_DEN_LDC |-> active_write_format_code_o == `TFS_WTF_LDC)
        else $error("bad code");
    a_code_ld: assert property (density_o == `TFS_DEN_LD |-> active_write_format_code_o == `TFS_WTF_LD)
        else $error("bad code");
    a_density_legal: assert property (density_o inside {8'h8c, 8'h15, 8'h90, 8'h14})
        else $error("bad density");
    a_comp_fmt: assert property (compress_on_write_enable_o && $stable(density_o) |-> density_o inside {8'h8c, 8'h90})
        else $error("compress on plain format");
    a_hdc_append: assert property (write_go_o && density_o == 8'h8c && !logical_tape_start_i
        && !tape_blank_i |-> ##[0:4] (compress_on_write_enable_o && decompress_on_read_enable_o)) else $error("hdc bits");
    // Go shows two edges after the completion edge of the command write
    a_go_cause: assert property (write_go_o |-> $past(pready_o && pwrite_i && paddr_i == `TFS_REG_CMD, 2))
        else $error("go without command");
    a_go_pulse: assert property (write_go_o |=> !write_go_o) else $error("go held");
    a_go_clears: assert property (write_go_o |-> ##[0:2] !write_reject_o) else $error("reject stuck");
endmodule : tfs_chk
bind tfs_top tfs_chk u_chk (.*);
`default_nettype wire

// ==== tfs_host.sv ====
// Initiator model issuing tape commands over the register bus.
`default_nettype none
module tfs_host (
    // Clock
    input wire logic clk_sys_i,
    // Bus master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus from time zero
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h0;
        pwdata_o = 32'h0;
    end
    // One transfer; error comes back unknown when the slave never answers
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        r = 32'h0;
        e = 1'bx;
        @(posedge clk_sys_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_sys_i);
        penable_o <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            @(posedge clk_sys_i);
            if (pready_i) begin
                r = prdata_i;
                e = pslverr_i;
                break;
            end
        end
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
endmodule : tfs_host
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the tape format selector.
`default_nettype none
`include "tfs_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Signals and model tables
    // ****
    logic clk_sys_i;
    logic rstn_i;
    logic ld, st, bl, e, acc;
    logic [1:0] rf;
    logic [2:0] mk;
    logic [31:0] r;
    logic [31:0] seed = 32'h4f;
    wire logic ps, pe, pw, rdy, err, go, rej, dce, dde;
    wire logic [11:0] pa;
    wire logic [31:0] wd, rd;
    wire logic [7:0] den;
    wire logic [2:0] code;
    int n_fail = 0;
    int checked = 0;
    int den_tab[4] = '{8'h8c, 8'h15, 8'h90, 8'h14};
    int code_tab[4] = '{2, 0, 3, 1};
    // Legal append marks per format, bit index is the mark code
    int ok_tab[4] = '{5'h1e, 5'h16, 5'h12, 5'h12};
    tfs_top u_tfs_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(ps), .penable_i(pe), .pwrite_i(pw),
        .paddr_i(pa), .pwdata_i(wd), .prdata_o(rd), .pready_o(rdy), .pslverr_o(err), .tape_loaded_i(ld),
        .logical_tape_start_i(st), .tape_blank_i(bl), .recorded_fmt_i(rf), .position_mark_i(mk),
        .density_o(den), .active_write_format_code_o(code), .compress_on_write_enable_o(dce),
        .decompress_on_read_enable_o(dde), .write_go_o(go), .write_reject_o(rej));
    tfs_host u_host (.clk_sys_i(clk_sys_i), .psel_o(ps), .penable_o(pe), .pwrite_o(pw), .paddr_o(pa),
        .pwdata_o(wd), .prdata_i(rd), .pready_i(rdy), .pslverr_i(err));
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task report_and_stop();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            $display("unexpected at %0t: got %h exp %h", $time, g, x);
            n_fail++;
        end
    endtask : chk
    // A hung slave ends the run at once
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic f);
        u_host.xfer(w, a, d, q, f);
        if (f === 1'bx) begin
            n_fail++;
            report_and_stop();
        end
    endtask : bus
    // Pins pass synchronisers, so settle a few edges
    task pins(input logic l, input logic s, input logic b, input logic [1:0] f, input logic [2:0] m);
        @(posedge clk_sys_i);
        ld <= l;
        st <= s;
        bl <= b;
        rf <= f;
        mk <= m;
        repeat (5) @(posedge clk_sys_i);
        #1;
    endtask : pins
    task wr_cmd(input logic [7:0] op);
        bus(1'b1, `TFS_REG_CMD, {24'h0, op}, r, e);
        acc = 1'b0;
        repeat (6) begin
            @(posedge clk_sys_i);
            #1;
            if (go === 1'b1) acc = 1'b1;
        end
    endtask : wr_cmd
    initial begin
        #2000000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        {rstn_i, ld, st, bl, rf, mk} = 9'h060;
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        pins(1'b1, 1'b1, 1'b1, 2'h0, 3'h0);
        bus(1'b0, `TFS_REG_CTRL, 32'h0, r, e);
        chk(r, 32'h3);
        chk(e, 1'b0);
        chk(den, 8'h8c);
        bus(1'b0, 12'hff0, 32'h0, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `TFS_REG_DEN, den_tab[i], r, e);
            bus(1'b0, `TFS_REG_DEN, 32'h0, r, e);
            chk(r[7:0], den_tab[i]);
            wr_cmd(8'h0a);
            chk(acc, 1'b1);
            chk(code, code_tab[i]);
        end
        for (int f = 0; f < 4; f++) begin
            pins(1'b0, 1'b1, 1'b0, f[1:0], 3'h0);
            bus(1'b1, `TFS_REG_CTRL, 32'h0, r, e);
            pins(1'b1, 1'b1, 1'b0, f[1:0], 3'h0);
            bus(1'b1, `TFS_REG_CMD, f[0] ? 32'h08 : 32'h11, r, e);
            pins(1'b1, 1'b0, 1'b0, f[1:0], 3'h0);
            chk(den, den_tab[f]);
            chk(code, code_tab[f]);
            chk(dde, !f[0]);
            for (int m = 0; m < 5; m++) begin
                pins(1'b1, 1'b0, 1'b0, f[1:0], m[2:0]);
                wr_cmd(rnd() & 32'h1 ? 8'h0a : 8'h10);
                chk(acc, ok_tab[f][m]);
                chk(rej, !ok_tab[f][m]);
                chk(den, den_tab[f]);
            end
            if (f == 0) chk({dce, dde}, 2'h3);
            else chk(dce, 1'b0);
            pins(1'b1, 1'b1, 1'b0, f[1:0], 3'h0);
            bus(1'b1, `TFS_REG_DEN, den_tab[(f + 1) % 4], r, e);
            chk(den, den_tab[f]);
            wr_cmd(8'h0a);
            chk({acc, den}, {1'b1, den_tab[f][7:0]});
        end
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
